// File: rtl/qdc_pkg.sv
package qdc_pkg;
	// Sizes of the command word and the converter channels
	localparam int NCHAN = 4;
	localparam int DATA_W = 12;
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam logic [4:0] WORD_BITS = 5'h10;

	// Field positions inside the command word
	localparam int SEL_MSB = 15;
	localparam int SEL_LSB = 14;
	localparam int CTL_MSB = 13;
	localparam int CTL_LSB = 12;
	localparam int CODE_MSB = 15;
	localparam int CODE_LSB = 12;
	localparam int DATA_MSB = 11;

	// Control field values that load one input register
	localparam logic [1:0] CTL_LOAD = 2'h1;
	localparam logic [1:0] CTL_LOAD_UPD = 2'h3;

	// Full four-bit codes with no channel meaning
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0,
		CMD_UPO_LO = 4'h2,
		CMD_UPDATE = 4'h4,
		CMD_UPO_HI = 4'h6,
		CMD_BCAST = 4'h8,
		CMD_MODE0 = 4'ha,
		CMD_SHDN = 4'hc,
		CMD_MODE1 = 4'he
	} qdc_cmd_t;

	// Pin bundle order and idle levels for the synchroniser
	localparam int PIN_SCLK = 0;
	localparam int PIN_CSN = 1;
	localparam int PIN_DIN = 2;
	localparam int PIN_LOCKN = 3;
	localparam int PIN_CLRN = 4;
	localparam int PIN_W = 5;
	localparam logic [4:0] PIN_RST = 5'h1a;

	// Register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_LAST = 8'h08;
	localparam logic [3:0] REG_DAC_PAGE = 4'h1;
	localparam logic [3:0] REG_IN_PAGE = 4'h2;

	// Control and status bit positions, reset values
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int STAT_SHDN_BIT = 0;
	localparam int STAT_MODE_BIT = 1;
	localparam int STAT_UPO_BIT = 2;
	localparam int STAT_LOCK_BIT = 3;
	localparam int STAT_SHORT_BIT = 4;
	localparam logic ECHO_MODE_RST = 1'b0;
	localparam logic UPO_RST = 1'b0;
	localparam logic [11:0] CODE_ZERO = 12'h000;
endpackage

// File: rtl/qdc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pins from outside the clock domain
module qdc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// First stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else if (ce_i) begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // qdc_sync

// File: rtl/qdc_chan.sv
`timescale 1ns/10ps
// One converter channel: input register followed by DAC register
module qdc_chan (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic ld_in_i,
	input wire logic upd_i,
	input wire logic [11:0] data_i,
	output logic [11:0] in_o,
	output logic [11:0] dac_o
);
	logic [11:0] in_r;
	logic [11:0] dac_r;
	logic [11:0] in_nxt;
	logic [11:0] dac_nxt;

	// A load and an update in one event pass the new code straight on
	assign in_nxt = clear_i ? qdc_pkg::CODE_ZERO : (ld_in_i ? data_i : in_r);
	assign dac_nxt = clear_i ? qdc_pkg::CODE_ZERO : (upd_i ? in_nxt : dac_r);

	// Both registers power up at zero code
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			in_r <= qdc_pkg::CODE_ZERO;
			dac_r <= qdc_pkg::CODE_ZERO;
		end else if (ce_i) begin
			in_r <= in_nxt;
			dac_r <= dac_nxt;
		end
	end

	assign in_o = in_r;
	assign dac_o = dac_r;
endmodule // qdc_chan

// File: rtl/qdc_cmd_port.sv
`timescale 1ns/10ps
// What this block does
// - Commands are sixteen bits, most significant first
// - Word is select, control, then twelve data
// - Control 01 loads one input register only
// - Control 11 loads input, then updates all
// - Code 0100 updates all DACs, exits shutdown
// - Code 1000 broadcasts data everywhere, exits shutdown
// - Code 1100 sleeps only with lockout high
// - Codes 0010/0110 drive user output low/high
// - Code 0000 changes no register but the last executed word
// - Code 1110 selects rising echo, updates all
// - Code 1010 selects falling echo, updates all
// - Chip select high idles the serial logic
// - Data sampled on serial clock rising edge
// - Command executes on chip select rising
// - Echo lags 16.5 or 16 clocks
// - Echo defaults to falling edge mode
// - Lockout low disables requested shutdown
// - Lockout falling edge wakes from shutdown
// - Clear zeroes registers, user output, echo
// - Shutdown keeps serial port and input contents
// - Power-up clears input and DAC registers
module qdc_cmd_port (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic serial_clock_i,
	input wire logic chip_select_n_i,
	input wire logic serial_data_in_i,
	input wire logic shutdown_lockout_n_i,
	input wire logic clear_n_i,
	output logic serial_data_out_o,
	output logic user_output_pin_o,
	output logic shutdown_o,
	output logic echo_mode_o,
	output logic [11:0] dac_code_a_o,
	output logic [11:0] dac_code_b_o,
	output logic [11:0] dac_code_c_o,
	output logic [11:0] dac_code_d_o
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	logic [4:0] pin_s;
	logic [4:0] pin_d_r;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic lock_fall;
	logic cs_n_s;
	logic din_s;
	logic lock_n_s;

	qdc_sync #(
		.WIDTH(qdc_pkg::PIN_W),
		.RST_VAL(qdc_pkg::PIN_RST)
	) u_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i({clear_n_i, shutdown_lockout_n_i, serial_data_in_i, chip_select_n_i,
			serial_clock_i}),
		.q_o(pin_s)
	);

	// Delayed copy of the synchronised pins for edges
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_d_r <= qdc_pkg::PIN_RST;
		end else if (ce_i) begin
			pin_d_r <= pin_s;
		end
	end

	// Edge strobes, one cycle each
	assign cs_n_s = pin_s[qdc_pkg::PIN_CSN];
	assign din_s = pin_s[qdc_pkg::PIN_DIN];
	assign lock_n_s = pin_s[qdc_pkg::PIN_LOCKN];
	assign sclk_rise = pin_s[qdc_pkg::PIN_SCLK] & ~pin_d_r[qdc_pkg::PIN_SCLK];
	assign sclk_fall = ~pin_s[qdc_pkg::PIN_SCLK] & pin_d_r[qdc_pkg::PIN_SCLK];
	assign cs_rise = cs_n_s & ~pin_d_r[qdc_pkg::PIN_CSN];
	assign lock_fall = ~lock_n_s & pin_d_r[qdc_pkg::PIN_LOCKN];

	////////////////////////////////////////////////////////////////////////////
	// Bus slave signals

	logic ctrl_en_r;
	logic ack_r;
	logic wr_go;
	logic rd_cap;
	logic soft_clr;
	logic stat_w1c;
	logic [31:0] rd_mux;
	logic [31:0] readdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Serial shift register, bit count and echo

	logic [15:0] shift_r;
	logic [4:0] cnt_r;
	logic msb_r;
	logic dout_r;
	logic echo_mode_r;
	logic active;
	logic shift_en;
	logic clear;

	assign clear = ~pin_s[qdc_pkg::PIN_CLRN] | soft_clr;
	assign active = ~cs_n_s & ctrl_en_r;
	assign shift_en = active & sclk_rise;

	// Shift in MSB first; count saturates at a full word
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_r <= '0;
			cnt_r <= '0;
			msb_r <= 1'b0;
		end else if (ce_i) begin
			if (shift_en) begin
				shift_r <= {shift_r[14:0], din_s};
				msb_r <= shift_r[15];
			end
			if (cs_n_s) begin
				cnt_r <= '0;
			end else if (shift_en && cnt_r != qdc_pkg::WORD_BITS) begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end

	// Echo output: rising mode sends at once, falling mode half a clock later
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dout_r <= 1'b0;
		end else if (ce_i) begin
			if (clear) begin
				dout_r <= 1'b0;
			end else if (active && echo_mode_r && sclk_rise) begin
				dout_r <= shift_r[15];
			end else if (active && !echo_mode_r && sclk_fall) begin
				dout_r <= msb_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic exec;
	logic short_frame;
	logic [3:0] code;
	logic [1:0] sel;
	logic [1:0] ctl;
	logic [11:0] data;
	logic is_load;
	logic upd_all;
	logic wake;
	logic sleep;
	logic [3:0] ld_in;

	assign code = shift_r[qdc_pkg::CODE_MSB:qdc_pkg::CODE_LSB];
	assign sel = shift_r[qdc_pkg::SEL_MSB:qdc_pkg::SEL_LSB];
	assign ctl = shift_r[qdc_pkg::CTL_MSB:qdc_pkg::CTL_LSB];
	assign data = shift_r[qdc_pkg::DATA_MSB:0];
	assign exec = cs_rise & ctrl_en_r & (cnt_r == qdc_pkg::WORD_BITS) & ~clear;
	assign short_frame = cs_rise & ctrl_en_r & (cnt_r != qdc_pkg::WORD_BITS) & (cnt_r != '0);
	assign is_load = (ctl == qdc_pkg::CTL_LOAD) | (ctl == qdc_pkg::CTL_LOAD_UPD);
	assign upd_all = exec & ((ctl == qdc_pkg::CTL_LOAD_UPD) | (code == qdc_pkg::CMD_UPDATE)
		| (code == qdc_pkg::CMD_BCAST) | (code == qdc_pkg::CMD_MODE0)
		| (code == qdc_pkg::CMD_MODE1));
	assign wake = (exec & ((code == qdc_pkg::CMD_UPDATE) | (code == qdc_pkg::CMD_BCAST)))
		| lock_fall;
	assign sleep = exec & (code == qdc_pkg::CMD_SHDN) & lock_n_s;

	////////////////////////////////////////////////////////////////////////////
	// Channels

	logic [11:0] in_w [4];
	logic [11:0] dac_w [4];

	// One input and DAC register pair per channel
	genvar gi;
	generate
		for (gi = 0; gi < qdc_pkg::NCHAN; gi++) begin : g_chan
			assign ld_in[gi] = exec & ((is_load & (sel == 2'(gi)))
				| (code == qdc_pkg::CMD_BCAST));
			qdc_chan u_chan (
				.clk_i(clk_i),
				.rstn_i(rstn_i),
				.ce_i(ce_i),
				.clear_i(clear),
				.ld_in_i(ld_in[gi]),
				.upd_i(upd_all),
				.data_i(data),
				.in_o(in_w[gi]),
				.dac_o(dac_w[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Mode, user output and shutdown state

	logic shdn_r;
	logic upo_r;
	logic short_r;
	logic [15:0] last_r;

	// Shutdown keeps input contents; only the flag changes
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shdn_r <= 1'b0;
			upo_r <= qdc_pkg::UPO_RST;
			echo_mode_r <= qdc_pkg::ECHO_MODE_RST;
		end else if (ce_i) begin
			if (clear) begin
				shdn_r <= 1'b0;
				upo_r <= qdc_pkg::UPO_RST;
				echo_mode_r <= qdc_pkg::ECHO_MODE_RST;
			end else begin
				if (wake) begin
					shdn_r <= 1'b0;
				end else if (sleep) begin
					shdn_r <= 1'b1;
				end
				if (exec && code == qdc_pkg::CMD_UPO_LO) begin
					upo_r <= 1'b0;
				end else if (exec && code == qdc_pkg::CMD_UPO_HI) begin
					upo_r <= 1'b1;
				end
				if (exec && code == qdc_pkg::CMD_MODE1) begin
					echo_mode_r <= 1'b1;
				end else if (exec && code == qdc_pkg::CMD_MODE0) begin
					echo_mode_r <= 1'b0;
				end
			end
		end
	end

	// Short-frame flag and last executed word; setting beats clearing
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			short_r <= 1'b0;
			last_r <= '0;
		end else if (ce_i) begin
			if (short_frame) begin
				short_r <= 1'b1;
			end else if (stat_w1c) begin
				short_r <= 1'b0;
			end
			if (exec) begin
				last_r <= shift_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then the answer

	logic req;
	logic is_ctrl;
	logic is_stat;
	logic is_last;
	logic is_dac;
	logic is_in;
	logic [1:0] ridx;

	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_r;
	assign wr_go = avs_write_i & ack_r;
	assign rd_cap = avs_read_i & ~ack_r;
	assign ridx = avs_address_i[3:2];
	assign is_ctrl = avs_address_i == qdc_pkg::REG_CTRL;
	assign is_stat = avs_address_i == qdc_pkg::REG_STAT;
	assign is_last = avs_address_i == qdc_pkg::REG_LAST;
	assign is_dac = (avs_address_i[7:4] == qdc_pkg::REG_DAC_PAGE) & (avs_address_i[1:0] == 2'h0);
	assign is_in = (avs_address_i[7:4] == qdc_pkg::REG_IN_PAGE) & (avs_address_i[1:0] == 2'h0);
	assign soft_clr = wr_go & is_ctrl & avs_byteenable_i[0]
		& avs_writedata_i[qdc_pkg::CTRL_CLR_BIT];
	assign stat_w1c = wr_go & is_stat & avs_byteenable_i[0]
		& avs_writedata_i[qdc_pkg::STAT_SHORT_BIT];

	// Read selection; unmapped addresses read zero
	assign rd_mux = is_ctrl ? {31'h0, ctrl_en_r}
		: is_stat ? {27'h0, short_r, lock_n_s, upo_r, echo_mode_r, shdn_r}
		: is_last ? {16'h0, last_r}
		: is_dac ? {20'h0, dac_w[ridx]}
		: is_in ? {20'h0, in_w[ridx]}
		: 32'h0;

	// Handshake, read capture and control write
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_r <= 1'b0;
			readdata_r <= '0;
			ctrl_en_r <= qdc_pkg::CTRL_EN_RST;
		end else if (ce_i) begin
			ack_r <= req & ~ack_r;
			if (rd_cap) begin
				readdata_r <= rd_mux;
			end
			if (wr_go && is_ctrl && avs_byteenable_i[0]) begin
				ctrl_en_r <= avs_writedata_i[qdc_pkg::CTRL_EN_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign avs_readdata_o = readdata_r;
	assign serial_data_out_o = dout_r;
	assign user_output_pin_o = upo_r;
	assign shutdown_o = shdn_r;
	assign echo_mode_o = echo_mode_r;
	assign dac_code_a_o = dac_w[0];
	assign dac_code_b_o = dac_w[1];
	assign dac_code_c_o = dac_w[2];
	assign dac_code_d_o = dac_w[3];

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	shift_in_a: assert property (ce_i && shift_en |=> shift_r == $past({shift_r[14:0], din_s}))
		else $error("shift register did not take the data bit");
	idle_hold_a: assert property (ce_i && cs_n_s |=> $stable(shift_r) && cnt_r == 5'h00)
		else $error("serial logic moved while deselected");
	load_one_a: assert property (ce_i && exec && ctl == qdc_pkg::CTL_LOAD
		|=> in_w[$past(sel)] == $past(data) && dac_w[0] == $past(dac_w[0])
		&& dac_w[3] == $past(dac_w[3]))
		else $error("input-only load disturbed a DAC register");
	load_upd_a: assert property (ce_i && exec && ctl == qdc_pkg::CTL_LOAD_UPD
		|=> dac_w[$past(sel)] == $past(data) && dac_w[$past(sel + 2'h1)] == in_w[$past(sel + 2'h1)])
		else $error("load and update gave wrong DAC contents");
	bcast_a: assert property (ce_i && exec && code == qdc_pkg::CMD_BCAST
		|=> dac_w[0] == $past(data) && in_w[2] == $past(data) && !shdn_r)
		else $error("broadcast did not load all registers");
	sleep_gate_a: assert property (ce_i && exec && code == qdc_pkg::CMD_SHDN && !lock_fall
		|=> shdn_r == ($past(lock_n_s) || $past(shdn_r)))
		else $error("shutdown ignored lockout level");
	user_pin_a: assert property (ce_i && exec && code == qdc_pkg::CMD_UPO_HI
		|=> user_output_pin_o ##1 user_output_pin_o || $past(clear) || $past(exec))
		else $error("user output not driven high");
	nop_a: assert property (ce_i && exec && code == qdc_pkg::CMD_NOP
		|=> $stable(dac_code_a_o) && $stable(dac_code_d_o) && in_w[1] == $past(in_w[1]))
		else $error("no-op changed a register");
	mode_sel_a: assert property (ce_i && exec && (code == qdc_pkg::CMD_MODE1
		|| code == qdc_pkg::CMD_MODE0) |=> echo_mode_r == $past(code[2]) && dac_w[1] == in_w[1])
		else $error("echo mode command misapplied");
	only_exec_a: assert property (ce_i && !exec && !clear |=> $stable(dac_code_b_o))
		else $error("DAC register changed outside chip select rising");
	wake_a: assert property (ce_i && shdn_r && lock_fall |=> !shdn_r)
		else $error("lockout falling edge did not wake");
	clear_a: assert property (ce_i && clear |=> dac_code_c_o == 12'h000 && in_w[0] == 12'h000
		&& !user_output_pin_o && !serial_data_out_o)
		else $error("clear left state behind");
	echo_rise_a: assert property (ce_i && active && echo_mode_r && sclk_rise && !clear
		|=> serial_data_out_o == $past(shift_r[15]))
		else $error("rising-edge echo bit wrong");
	bus_ans_a: assert property (ce_i && req && !ack_r |=> !avs_waitrequest_o || !req)
		else $error("bus answer later than one wait cycle");

	bcast_c: cover property (exec && code == qdc_pkg::CMD_BCAST);
	sleep_c: cover property (sleep ##[1:1000] lock_fall);
	mode1_c: cover property (exec && code == qdc_pkg::CMD_MODE1);
	short_c: cover property (short_frame);
endmodule // qdc_cmd_port

// File: verif/qdc_host_model.sv
`timescale 1ns/10ps
// Host end of the serial link: sends frames and records the echo line
module qdc_host_model (
	input wire logic clk_i,
	input wire logic serial_data_out_i,
	output logic serial_clock_o,
	output logic chip_select_n_o,
	output logic serial_data_in_o
);
	logic echo_q[$];

	// Idle pins: select high, link clock parked low
	initial begin
		serial_clock_o = 1'b0;
		chip_select_n_o = 1'b1;
		serial_data_in_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One frame of n bits, MSB first, link clock 160 ns, still outside the frame
	task automatic send(input logic [31:0] w, input int n);
		echo_q = {};
		@(posedge clk_i);
		chip_select_n_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_data_in_o <= w[i];
			repeat (8) @(posedge clk_i);
			serial_clock_o <= 1'b1;
			repeat (8) @(posedge clk_i);
			// Echo sampled late in the high phase, just before the fall
			if (n - 1 - i >= 16)
				echo_q.push_back(serial_data_out_i);
			serial_clock_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		chip_select_n_o <= 1'b1;
		serial_data_in_o <= ~w[0]; // Released line shows no stale value
		repeat (8) @(posedge clk_i);
	endtask
endmodule // qdc_host_model

// File: verif/quad_dac_serial_command_port_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module quad_dac_serial_command_port_bench;
	logic clk_i, rstn_i, ce, lock_n, clr_n, rd, wr, wait_o, sclk, csn, din, dout, user_output_pin, shdn, mode;
	logic [7:0] adr;
	logic [31:0] wdata, rdata, tmp;
	logic [11:0] dac [4];
	logic [11:0] in_m [4];
	logic [11:0] dac_m [4];
	logic upo_m, shdn_m, mode_m;
	int error_cnt, compares;

	qdc_cmd_port qdc_cmd_port_inst (
		.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.serial_clock_i(sclk), .chip_select_n_i(csn), .serial_data_in_i(din),
		.shutdown_lockout_n_i(lock_n), .clear_n_i(clr_n), .serial_data_out_o(dout),
		.user_output_pin_o(user_output_pin), .shutdown_o(shdn), .echo_mode_o(mode),
		.dac_code_a_o(dac[0]), .dac_code_b_o(dac[1]), .dac_code_c_o(dac[2]),
		.dac_code_d_o(dac[3])
	);

	qdc_host_model qdc_host_model_inst (
		.clk_i(clk_i), .serial_data_out_i(dout), .serial_clock_o(sclk),
		.chip_select_n_o(csn), .serial_data_in_o(din)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus access: hold until waitrequest seen low, then release
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		adr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk_i);
		end while (wait_o !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_i);
	endtask

	// Reference behaviour of one executed command word
	task automatic apply(input logic [15:0] w);
		if (w[13:12] == 2'h1) begin
			in_m[w[15:14]] = w[11:0];
		end else if (w[13:12] == 2'h3) begin
			in_m[w[15:14]] = w[11:0];
			dac_m = in_m;
		end else begin
			case (w[15:12])
				4'h4: begin
					dac_m = in_m;
					shdn_m = 1'b0;
				end
				4'h8: begin
					in_m = '{w[11:0], w[11:0], w[11:0], w[11:0]};
					dac_m = in_m;
					shdn_m = 1'b0;
				end
				4'hc: if (lock_n) shdn_m = 1'b1;
				4'h2: upo_m = 1'b0;
				4'h6: upo_m = 1'b1;
				4'he: begin
					mode_m = 1'b1;
					dac_m = in_m;
				end
				4'ha: begin
					mode_m = 1'b0;
					dac_m = in_m;
				end
				default: ;
			endcase
		end
	endtask

	// Compare pins and readable registers with the reference
	task automatic check_all();
		for (int c = 0; c < 4; c++) begin
			`CHK(dac[c], dac_m[c])
			bus(1'b0, 8'h20 + 8'(4 * c), 32'h0, tmp);
			`CHK(tmp, {20'h0, in_m[c]})
		end
		`CHK({user_output_pin, shdn, mode}, {upo_m, shdn_m, mode_m})
		bus(1'b0, 8'h04, 32'h0, tmp);
		`CHK(tmp[2:0], {upo_m, mode_m, shdn_m})
	endtask

	// Send a frame, check the echo of long frames, then execute in the model
	task automatic frame(input logic [31:0] w, input int n, input bit exec);
		qdc_host_model_inst.send(w, n);
		// Falling-edge echo lags half a clock more; its first sample predates the frame
		if (n == 32)
			for (int j = 16; j < 32; j++)
				if (j + int'(mode_m) > 16)
					`CHK(qdc_host_model_inst.echo_q[j - 16], w[48 - j - int'(mode_m)])
		if (exec)
			apply(w[15:0]);
		check_all();
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#800000;
		error_cnt++;
		tally_and_finish();
	end

	// Test sequence
	initial begin
		{rstn_i, rd, wr, adr, wdata, lock_n, clr_n} = {1'b0, 1'b0, 1'b0, 8'h0, 32'h0, 2'h3};
		{upo_m, shdn_m, mode_m} = 3'h0;
		in_m = '{default: 12'h0};
		dac_m = '{default: 12'h0};
		error_cnt = 0;
		compares = 0;
		ce = 1'b1;
		void'($urandom(32'h60f7cd98));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check_all();
		$display("test reset done");
		for (int c = 0; c < 16; c++)
			frame({16'h0, 4'(c), 12'($urandom)}, 16, 1'b1);
		$display("test codes done");
		foreach (tmp[i]) if (i < 3)
			frame({16'($urandom), 4'({4'he, 4'h8, 4'ha} >> (4 * (2 - i))),
				12'($urandom)}, 32, 1'b1);
		$display("test echo done");
		lock_n <= 1'b0;
		frame(32'hc000, 16, 1'b1);
		lock_n <= 1'b1;
		frame(32'hc123, 16, 1'b1);
		lock_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		shdn_m = 1'b0;
		check_all();
		lock_n <= 1'b1;
		$display("test lockout done");
		frame(32'h4abc, 8, 1'b0);
		`CHK(tmp[4], 1'b1)
		bus(1'b1, 8'h04, 32'h10, tmp);
		bus(1'b0, 8'h04, 32'h0, tmp);
		`CHK(tmp[4], 1'b0)
		bus(1'b1, 8'h00, 32'h0, tmp);
		frame(32'h8fff, 16, 1'b0);
		bus(1'b1, 8'h00, 32'h1, tmp);
		bus(1'b1, 8'h10, 32'hfff, tmp);
		bus(1'b1, 8'h40, 32'h5a5, tmp);
		bus(1'b0, 8'h40, 32'h0, tmp);
		`CHK(tmp, 32'h0)
		check_all();
		$display("test registers done");
		frame(32'h6000, 16, 1'b1);
		// Enable low freezes all state, a clear pulse on the pin included
		ce <= 1'b0;
		clr_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		clr_n <= 1'b1;
		repeat (8) @(posedge clk_i);
		ce <= 1'b1;
		repeat (4) @(posedge clk_i);
		check_all();
		$display("test enable done");
		clr_n <= 1'b0;
		repeat (8) @(posedge clk_i);
		in_m = '{default: 12'h0};
		dac_m = '{default: 12'h0};
		{upo_m, shdn_m, mode_m} = 3'h0;
		check_all();
		`CHK(dout, 1'b0)
		clr_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		$display("test clear done");
		// Last word readback, then the software clear strobe
		frame(32'h8abc, 16, 1'b1);
		bus(1'b0, 8'h08, 32'h0, tmp);
		`CHK(tmp, 32'h8abc)
		bus(1'b1, 8'h00, 32'h3, tmp);
		in_m = '{default: 12'h0};
		dac_m = '{default: 12'h0};
		{upo_m, shdn_m, mode_m} = 3'h0;
		check_all();
		bus(1'b0, 8'h00, 32'h0, tmp);
		`CHK(tmp, 32'h1)
		$display("test soft clear done");
		tally_and_finish();
	end
endmodule // quad_dac_serial_command_port_bench
